// ### logic/logic_tile.sv
/*
 * Programmable logic tile: four logic cells in two slices with look-up tables usable as
 * logic, distributed RAM or shift registers, storage elements, wide multiplexers, carry
 * chains, feedthroughs and two tri-state bus drivers, configured over Avalon-MM.
 * Assumes all fabric inputs are synchronous to clock; slice clocks are sampled levels.
 */
`timescale 1ns/10ps
`include "tile_cfg.svh"

// How it works
// - Cell has LUT, carry, storage; LUT feeds both.
// - Four cells, two slices of two.
// - Each LUT works as 16x1 synchronous RAM.
// - Slice LUT pair: 16x2, 32x1, dual-port RAM.
// - Each LUT works as 16-stage shift register.
// - Storage is flip-flop or transparent latch.
// - Storage data from LUT, bypass, sum or carry.
// - Each slice has clock and clock enable.
// - Init force loads configured initial value.
// - Opposite force loads complement of initial value.
// - Forces synchronous, optionally asynchronous by configuration.
// - Slice clock, enable, forces invertible, shared by both cells.
// - Slice mux picks between its two LUTs.
// - Tile mux picks between two slice muxes.
// - Four direct feedthrough paths, one per cell.
// - Two carry chains, two bits each, vertical.
// - Per-cell XOR makes one-bit full adder.
// - Per-cell AND gate helps multipliers.
// - Carry path cascades LUTs into wide functions.
// - Two tri-state drivers, own enable and data.
module logic_tile #(
   parameter int CELLS = 4,
   parameter int SLICES = 2
)(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic [15:0] lut_addr,
   input wire logic [3:0] bypass_in,
   input wire logic [1:0] slice_clk,
   input wire logic [1:0] slice_ce,
   input wire logic [1:0] init_force,
   input wire logic [1:0] opposite_force,
   input wire logic [1:0] slice_we,
   input wire logic [1:0] ram_addr_hi,
   input wire logic [1:0] five_input_mux_sel,
   input wire logic six_input_mux_sel,
   input wire logic [1:0] carry_in,
   input wire logic [3:0] feed_in,
   input wire logic [1:0] bus_drv_data,
   input wire logic [1:0] bus_drv_en,
   output logic [3:0] cell_out,
   output logic [3:0] sum_out,
   output logic [3:0] q_out,
   output logic [1:0] five_input_mux_out,
   output logic six_input_mux_out,
   output logic [1:0] carry_out,
   output logic [3:0] feed_out,
   output logic [1:0] bus_line_out,
   output logic [1:0] bus_line_oe
);

   // The slice clocks are not true clocks here: each is sampled as a level on the system
   // clock and a rising edge is recognised against the previous sample. This keeps the
   // whole tile in one clock domain, at the price that a slice clock must stay low for at
   // least one system cycle between pulses, or its next edge is lost.
   // Latch mode is likewise emulated: the storage element follows its data on every system
   // edge while the slice clock level is high, so it is transparent only at sample points.

   // Configuration and table state.
   logic [15:0] lut_q [CELLS];
   logic [19:0] cell_cfg_q;
   logic [15:0] slice_cfg_q;
   logic [3:0] q_q;
   logic [1:0] clk_prev_q;
   logic wait_q;
   logic [31:0] readdata_q;
   logic [31:0] rd_mux;
   logic bus_wr;

   // Registered fabric-facing outputs.
   logic [3:0] cell_out_q;
   logic [3:0] sum_out_q;
   logic [1:0] f5_q;
   logic f6_q;
   logic [1:0] carry_out_q;
   logic [3:0] feed_q;
   logic [1:0] bus_out_q;
   logic [1:0] bus_oe_q;

   // Per-slice decoded controls.
   tile_pkg::slice_mode_t mode [SLICES];
   logic [1:0] clk_lvl;
   logic [1:0] clk_edge;
   logic [1:0] ce_act;
   logic [1:0] init_act;
   logic [1:0] opp_act;
   logic [1:0] async_force;
   logic [1:0] ram_mode;
   logic [1:0] f5;

   // Per-cell combinational nets.
   logic [3:0] f;
   logic [3:0] cin;
   logic [3:0] cout;
   logic [3:0] sum;
   logic [3:0] d;
   logic [3:0] wr_en;
   logic [3:0] wr_data;
   logic [3:0] sh_en;
   logic [3:0] rd_addr [CELLS];
   logic [3:0] wr_addr [CELLS];

   // A bus write lands on the edge that ends its wait, the one edge the master samples it.
   assign bus_wr = write && !wait_q;

   // Slice controls: clock, enable and both forces pass through their own inversion; all serve both cells.
   genvar s;
   generate
      for (s = 0; s < SLICES; s++)
      begin : g_slice
         assign mode[s] = tile_pkg::slice_mode_t'(slice_cfg_q[`SLICE_FIELD_W*s + `SF_MODE_LSB +: 3]);
         assign clk_lvl[s] = slice_clk[s] ^ slice_cfg_q[`SLICE_FIELD_W*s + `SF_INV_CLK_BIT];
         assign ce_act[s] = slice_ce[s] ^ slice_cfg_q[`SLICE_FIELD_W*s + `SF_INV_CE_BIT];
         assign init_act[s] = init_force[s] ^ slice_cfg_q[`SLICE_FIELD_W*s + `SF_INV_INIT_BIT];
         assign opp_act[s] = opposite_force[s] ^ slice_cfg_q[`SLICE_FIELD_W*s + `SF_INV_OPP_BIT];
         assign async_force[s] = slice_cfg_q[`SLICE_FIELD_W*s + `SF_ASYNC_BIT];
         assign clk_edge[s] = clk_lvl[s] && !clk_prev_q[s];
         assign ram_mode[s] = (mode[s] == tile_pkg::mode_ram16x1) || (mode[s] == tile_pkg::mode_ram16x2) ||
            (mode[s] == tile_pkg::mode_ram32x1) || (mode[s] == tile_pkg::mode_ram_dual);
         // The slice mux joins its two tables into one five-input function.
         assign f5[s] = five_input_mux_sel[s] ? f[2*s+1] : f[2*s];
         // Each slice's chain enters at the even cell and leaves at the odd one.
         assign cin[2*s] = carry_in[s];
         assign cin[2*s+1] = cout[2*s];
      end
   endgenerate

   // Per-cell table read, write steering, carry and storage data selection.
   // In the paired memory modes both tables of a slice share the even cell's address, so
   // one address word drives the pair. The dual-port mode writes through the even address
   // but lets the odd table read at its own address, which gives the second read port.
   // The memory and shift modes still feed the table output into the carry and storage
   // paths, so arithmetic on memory contents needs no extra routing.
   genvar c;
   generate
      for (c = 0; c < CELLS; c++)
      begin : g_cell
         localparam int S = c / 2;
         localparam bit ODD = (c % 2) == 1;
         logic [3:0] own_addr;
         logic [3:0] even_addr;
         logic shared;
         logic di;
         assign own_addr = lut_addr[4*c +: 4];
         assign even_addr = lut_addr[8*S +: 4];
         assign shared = (mode[S] == tile_pkg::mode_ram16x2) || (mode[S] == tile_pkg::mode_ram32x1);
         // Paired modes read the odd table at the even cell's address; dual port reads its own.
         assign rd_addr[c] = (ODD && shared) ? even_addr : own_addr;
         // In 32x1 mode the even cell output carries the whole 32-word memory.
         assign f[c] = (!ODD && mode[S] == tile_pkg::mode_ram32x1 && ram_addr_hi[S]) ?
            lut_q[c | 1][even_addr] : lut_q[c][rd_addr[c]];
         assign wr_addr[c] = (mode[S] == tile_pkg::mode_ram16x1) ? own_addr : even_addr;
         assign wr_data[c] = ((mode[S] == tile_pkg::mode_ram32x1) || (mode[S] == tile_pkg::mode_ram_dual)) ?
            bypass_in[2*S] : bypass_in[c];
         assign wr_en[c] = ram_mode[S] && clk_edge[S] && ce_act[S] && slice_we[S] &&
            ((mode[S] != tile_pkg::mode_ram32x1) || (ram_addr_hi[S] == ODD));
         assign sh_en[c] = (mode[S] == tile_pkg::mode_shift) && clk_edge[S] && ce_act[S];
         // The generate input is the bypass or the dedicated AND of two table inputs.
         assign di = cell_cfg_q[`CELL_FIELD_W*c + `CF_DI_AND_BIT] ? (own_addr[0] & own_addr[1]) :
            bypass_in[c];
         // A true table picks carry-in, so a chain of tables with zero bypass forms a wide AND.
         assign cout[c] = f[c] ? cin[c] : di;
         assign sum[c] = f[c] ^ cin[c];
         always_comb
         begin
            case (tile_pkg::d_sel_t'(cell_cfg_q[`CELL_FIELD_W*c + `CF_DSEL_LSB +: 2]))
               tile_pkg::dsel_lut: d[c] = f[c];
               tile_pkg::dsel_bypass: d[c] = bypass_in[c];
               tile_pkg::dsel_sum: d[c] = sum[c];
               default: d[c] = cout[c];
            endcase
         end
      end
   endgenerate

   // Table contents: a bus write wins over a fabric write landing in the same cycle.
   // Software loading a table is taken as a reconfiguration, so the fabric write that
   // collides with it is dropped rather than merged into the new contents.
   // A cell is either a memory or a shifter in one mode, never both on one edge.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < CELLS; i++)
         begin
            lut_q[i] <= `LUT_RESET;
         end
      end
      else if (clk_en)
      begin
         for (int i = 0; i < CELLS; i++)
         begin
            if (bus_wr && address == (`LUT0_OFFSET + 6'(4*i)))
            begin
               lut_q[i] <= writedata[15:0];
            end
            else if (wr_en[i])
            begin
               lut_q[i][wr_addr[i]] <= wr_data[i];
            end
            else if (sh_en[i])
            begin
               lut_q[i] <= {lut_q[i][14:0], bypass_in[i]};
            end
         end
      end
   end

   // Storage elements; init force outranks opposite force when both are active.
   // Forces ignore the clock enable on purpose: an initialise must reach a stalled slice.
   // A synchronous force waits for a slice clock edge even when the cell is a latch, so
   // latch and flip-flop cells of one slice are forced at the same moment.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         q_q <= 4'h0;
      end
      else if (clk_en)
      begin
         for (int i = 0; i < CELLS; i++)
         begin
            if (init_act[i/2] && (async_force[i/2] || clk_edge[i/2]))
            begin
               q_q[i] <= cell_cfg_q[`CELL_FIELD_W*i + `CF_INIT_BIT];
            end
            else if (opp_act[i/2] && (async_force[i/2] || clk_edge[i/2]))
            begin
               q_q[i] <= ~cell_cfg_q[`CELL_FIELD_W*i + `CF_INIT_BIT];
            end
            else if (ce_act[i/2] && (cell_cfg_q[`CELL_FIELD_W*i + `CF_LATCH_BIT] ? clk_lvl[i/2] : clk_edge[i/2]))
            begin
               q_q[i] <= d[i];
            end
         end
      end
   end

   // Previous slice clock level, for edge detection.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         clk_prev_q <= 2'h0;
      end
      else if (clk_en)
      begin
         clk_prev_q <= clk_lvl;
      end
   end

   // Fabric outputs are registered so every tile output comes from a flip-flop.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         cell_out_q <= 4'h0;
         sum_out_q <= 4'h0;
         f5_q <= 2'h0;
         f6_q <= 1'b0;
         carry_out_q <= 2'h0;
         feed_q <= 4'h0;
         bus_out_q <= 2'h0;
         bus_oe_q <= 2'h0;
      end
      else if (clk_en)
      begin
         cell_out_q <= f;
         sum_out_q <= sum;
         f5_q <= f5;
         f6_q <= six_input_mux_sel ? f5[1] : f5[0];
         carry_out_q <= {cout[3], cout[1]};
         feed_q <= feed_in;
         bus_out_q <= bus_drv_data;
         bus_oe_q <= bus_drv_en;
      end
   end

   // Configuration registers.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         cell_cfg_q <= `CELL_CFG_RESET;
         slice_cfg_q <= `SLICE_CFG_RESET;
      end
      else if (clk_en && bus_wr)
      begin
         if (address == `CELL_CFG_OFFSET)
         begin
            cell_cfg_q <= writedata[19:0];
         end
         if (address == `SLICE_CFG_OFFSET)
         begin
            slice_cfg_q <= writedata[15:0];
         end
      end
   end

   // Read decode; unmapped offsets read as zero.
   always_comb
   begin
      case (address)
         `LUT0_OFFSET: rd_mux = {16'h0000, lut_q[0]};
         `LUT1_OFFSET: rd_mux = {16'h0000, lut_q[1]};
         `LUT2_OFFSET: rd_mux = {16'h0000, lut_q[2]};
         `LUT3_OFFSET: rd_mux = {16'h0000, lut_q[3]};
         `CELL_CFG_OFFSET: rd_mux = {12'h000, cell_cfg_q};
         `SLICE_CFG_OFFSET: rd_mux = {16'h0000, slice_cfg_q};
         `STATUS_OFFSET: rd_mux = {26'h0000000, carry_out_q, q_q};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Bus handshake: one wait cycle, then waitrequest low for one cycle with data ready.
   // The answer is always exactly one wait, also for unmapped offsets, so a master never
   // hangs on a bad address; such a write is simply dropped and such a read returns zero.
   // Waiting one cycle keeps the read mux off the output path at the cost of latency.
   always_ff @(posedge clock)
   begin
      if (!reset_n)
      begin
         wait_q <= 1'b1;
         readdata_q <= 32'h00000000;
      end
      else if (clk_en)
      begin
         if ((read || write) && wait_q)
         begin
            wait_q <= 1'b0;
            readdata_q <= read ? rd_mux : 32'h00000000;
         end
         else
         begin
            wait_q <= 1'b1;
         end
      end
   end

   // Every output port is a plain copy of a flip-flop, so no fabric path is combinational
   // from a tile input to a tile output and tiles can be chained without long loops.
   assign readdata = readdata_q;
   assign waitrequest = wait_q;
   assign cell_out = cell_out_q;
   assign sum_out = sum_out_q;
   assign q_out = q_q;
   assign five_input_mux_out = f5_q;
   assign six_input_mux_out = f6_q;
   assign carry_out = carry_out_q;
   assign feed_out = feed_q;
   assign bus_line_out = bus_out_q;
   assign bus_line_oe = bus_oe_q;

endmodule // logic_tile

// ### logic/tile_cfg.svh
/*
 * Register offsets, field positions and reset values of the logic tile.
 * Assumes byte addressing on an Avalon-MM slave with one 32-bit word per register.
 */
`ifndef TILE_CFG_SVH
`define TILE_CFG_SVH

// Register byte offsets.
`define LUT0_OFFSET 6'h00
`define LUT1_OFFSET 6'h04
`define LUT2_OFFSET 6'h08
`define LUT3_OFFSET 6'h0c
`define CELL_CFG_OFFSET 6'h10
`define SLICE_CFG_OFFSET 6'h14
`define STATUS_OFFSET 6'h18

// Per-cell configuration field, five bits for each cell.
`define CELL_FIELD_W 5
`define CF_DSEL_LSB 0
`define CF_LATCH_BIT 2
`define CF_INIT_BIT 3
`define CF_DI_AND_BIT 4

// Per-slice configuration field, eight bits for each slice.
`define SLICE_FIELD_W 8
`define SF_MODE_LSB 0
`define SF_ASYNC_BIT 3
`define SF_INV_CLK_BIT 4
`define SF_INV_CE_BIT 5
`define SF_INV_INIT_BIT 6
`define SF_INV_OPP_BIT 7

// Reset values.
`define LUT_RESET 16'h0000
`define CELL_CFG_RESET 20'h00000
`define SLICE_CFG_RESET 16'h0000

`endif

// ### logic/tile_pkg.sv
/*
 * Types shared by the logic tile: slice table modes and storage data sources.
 * Assumes nothing of its surroundings.
 */
package tile_pkg;

   // How the two look-up tables of one slice are used.
   typedef enum logic [2:0]
   {
      mode_logic,
      mode_ram16x1,
      mode_ram16x2,
      mode_ram32x1,
      mode_ram_dual,
      mode_shift
   } slice_mode_t;

   // Where a storage element takes its data from.
   typedef enum logic [1:0]
   {
      dsel_lut,
      dsel_bypass,
      dsel_sum,
      dsel_carry
   } d_sel_t;

endpackage

// ### testbench/logic_tile_properties.sv
/*
 * Port checker of the logic tile: bus handshake, reset, pass-through paths and clock enable.
 * Assumes one clock domain and a synchronous active-low reset, bound to the tile below.
 */
`timescale 1ns/10ps
module logic_tile_properties (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic six_input_mux_sel,
   input wire logic [3:0] feed_in,
   input wire logic [1:0] bus_drv_data,
   input wire logic [1:0] bus_drv_en,
   input wire logic [3:0] q_out,
   input wire logic [1:0] five_input_mux_out,
   input wire logic six_input_mux_out,
   input wire logic [3:0] feed_out,
   input wire logic [1:0] bus_line_out,
   input wire logic [1:0] bus_line_oe
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   // A request is taken only while the handshake is armed and the tile is clocked.
   sequence taken_s;
      (read || write) && waitrequest && clk_en;
   endsequence
   sequence answer_s;
      !waitrequest ##1 waitrequest;
   endsequence

   wait_answer_a: assert property (taken_s |=> answer_s) else $error("access not answered after one wait");
   wait_pulse_a: assert property (!waitrequest && clk_en |=> waitrequest) else $error("answer held too long");
   unmapped_read_a: assert property ((read && address > 6'h18) ##0 taken_s |=> readdata == 32'h0)
      else $error("unmapped read not zero");
   // The reset check must run while reset is low, so it keeps no disable condition.
   reset_out_a: assert property (disable iff (1'b0) !reset_n && clk_en |=> waitrequest && q_out == 4'h0)
      else $error("reset values wrong");
   feed_path_a: assert property (clk_en |=> feed_out == $past(feed_in)) else $error("feedthrough wrong");
   bus_drive_a: assert property (clk_en |=> bus_line_oe == $past(bus_drv_en) &&
      (bus_line_out & bus_line_oe) == ($past(bus_drv_data) & bus_line_oe)) else $error("bus driver wrong");
   six_mux_a: assert property (clk_en |=> six_input_mux_out ==
      ($past(six_input_mux_sel) ? five_input_mux_out[1] : five_input_mux_out[0])) else $error("six mux wrong");
   freeze_a: assert property (!clk_en |=> $stable(q_out) && $stable(waitrequest))
      else $error("state moved while disabled");
endmodule // logic_tile_properties

bind logic_tile logic_tile_properties i_props (.clock, .reset_n, .clk_en, .address, .read, .write, .readdata,
   .waitrequest, .six_input_mux_sel, .feed_in, .bus_drv_data, .bus_drv_en, .q_out, .five_input_mux_out,
   .six_input_mux_out, .feed_out, .bus_line_out, .bus_line_oe);

// ### testbench/fabric_model.sv
/*
 * Fabric model: neighbouring logic that makes slice clock pulses and resolves the bus lines.
 * Assumes the tile's system clock and a bench that asks for pulses through strobe.
 */
`timescale 1ns/10ps
module fabric_model (
   input wire logic clock,
   input wire logic [1:0] strobe,
   input wire logic [1:0] drive,
   input wire logic [1:0] drive_en,
   output logic [1:0] slice_clk,
   output logic [1:0] bus_wire
);
   // A pulse lasts one sample and is never directly followed by another, so every edge is seen.
   always_ff @(posedge clock)
   begin
      slice_clk <= strobe & ~slice_clk;
   end

   // The bus lines carry a pull-up, so a released line reads high rather than the last value.
   assign bus_wire = (drive & drive_en) | ~drive_en;
endmodule // fabric_model

// ### testbench/test_logic_tile.sv
/*
 * Self-checking bench of the logic tile: registers, logic paths, storage, memories, shifters.
 * Assumes the design files, the checker and the fabric model are compiled before it.
 */
`timescale 1ns/10ps
module test_logic_tile;
   logic clock = 0, reset_n = 0, clk_en = 1, read = 0, write = 0, six_input_mux_sel = 0, waitrequest;
   logic [5:0] address = 6'h00;
   logic [31:0] writedata = 32'h0, readdata, rd;
   logic [15:0] lut_addr = 16'h0;
   logic [3:0] bypass_in = 4'h0, feed_in = 4'h0, cell_out, sum_out, q_out, feed_out, exp;
   logic [1:0] strobe = 2'h0, slice_ce = 2'h0, init_force = 2'h0, opposite_force = 2'h0, slice_we = 2'h0;
   logic [1:0] five_input_mux_sel = 2'h0, carry_in = 2'h0, bus_drv_data = 2'h0, bus_drv_en = 2'h0;
   logic [1:0] ram_addr_hi = 2'h0;
   logic [3:0] andg = 4'h0;
   logic [1:0] slice_clk, five_input_mux_out, carry_out, bus_line_out, bus_line_oe, bus_wire;
   logic six_input_mux_out;
   int fails = 0, samples_checked = 0;
   int lut [4];

   logic_tile i_dut (.clock, .reset_n, .clk_en, .address, .read, .write, .writedata, .readdata, .waitrequest,
      .lut_addr, .bypass_in, .slice_clk, .slice_ce, .init_force, .opposite_force, .slice_we, .ram_addr_hi,
      .five_input_mux_sel, .six_input_mux_sel, .carry_in, .feed_in, .bus_drv_data, .bus_drv_en, .cell_out,
      .sum_out, .q_out, .five_input_mux_out, .six_input_mux_out, .carry_out, .feed_out, .bus_line_out,
      .bus_line_oe);
   fabric_model i_fabric (.clock, .strobe, .drive(bus_line_out), .drive_en(bus_line_oe), .slice_clk, .bus_wire);

   // Free-running system clock.
   always #25 clock = ~clock;

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         fails++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   // One bus access; the idle edge first keeps a release and the next request in separate steps.
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (waitrequest !== 1'b0 && n < 20);
      rd = readdata;
      read <= 0;
      write <= 0;
      if (n == 20)
      begin
         chk(1, 0);
         stop_test();
      end
   endtask

   // Random fabric inputs, then every combinational path compared with the table model.
   task automatic fabric_check();
      int f [4], f5 [2], co [4], ci;
      {lut_addr, bypass_in, feed_in, carry_in, five_input_mux_sel, six_input_mux_sel, bus_drv_data,
         bus_drv_en} <= {$urandom, $urandom};
      cyc(2);
      for (int c = 0; c < 4; c++)
      begin
         f[c] = lut[c][lut_addr[4*c+:4]];
         ci = c % 2 ? co[c-1] : carry_in[c/2];
         co[c] = f[c] ? ci : andg[c] ? lut_addr[4*c] & lut_addr[4*c+1] : bypass_in[c];
         chk(cell_out[c], f[c]);
         chk(sum_out[c], f[c] ^ ci);
      end
      for (int s = 0; s < 2; s++)
         f5[s] = five_input_mux_sel[s] ? f[2*s+1] : f[2*s];
      chk(carry_out, co[3] * 2 + co[1]);
      chk(five_input_mux_out, f5[1] * 2 + f5[0]);
      chk(six_input_mux_out, six_input_mux_sel ? f5[1] : f5[0]);
      chk(feed_out, feed_in);
      chk(bus_wire, bus_drv_data | (bus_drv_en ^ 2'h3));
   endtask

   task automatic pulse(input logic [1:0] m);
      strobe <= m;
      cyc(1);
      strobe <= 2'h0;
      cyc(3);
   endtask

   initial
   begin
      void'($urandom(32'h1bc60148));
      cyc(4);
      reset_n <= 1;
      // An unmapped write is dropped; every place then reads as zero.
      bus(1, 6'h1c, $urandom);
      for (int a = 0; a < 8; a++)
      begin
         bus(0, 6'(4 * a), 0);
         chk(rd, 0);
      end
      // Random tables in logic mode, then random traffic through all paths.
      for (int c = 0; c < 4; c++)
      begin
         lut[c] = $urandom & 32'hffff;
         bus(1, 6'(4 * c), lut[c]);
         bus(0, 6'(4 * c), 0);
         chk(rd, lut[c]);
      end
      repeat (8) fabric_check();
      clk_en <= 0;
      cyc(3);
      clk_en <= 1;
      // Storage from bypass inputs, cells 1 and 3 initialised to one; forces wait for a slice edge.
      bus(1, 6'h10, 32'h48521);
      exp = 4'h0;
      for (int s = 0; s < 4; s++)
      begin
         {bypass_in, slice_ce, init_force, opposite_force} <= {$urandom, {2{s != 3}}, {2{s == 1}}, {2{s == 2}}};
         cyc(3);
         chk(q_out, exp);
         pulse(2'h3);
         exp = s == 0 ? bypass_in : s == 1 ? 4'ha : 4'h5;
         chk(q_out, exp);
      end
      // Asynchronous forces need no slice edge; an inverted enable enables when low.
      bus(1, 6'h14, 32'h2828);
      init_force <= 2'h3;
      cyc(3);
      chk(q_out, 4'ha);
      init_force <= 2'h0;
      slice_ce <= 2'h0;
      pulse(2'h3);
      chk(q_out, bypass_in);
      // Slice 0 as two 16x1 memories, slice 1 as two shift registers, enables at random.
      bus(1, 6'h14, 32'h0501);
      slice_we <= 2'h1;
      repeat (24)
      begin
         {lut_addr, bypass_in, slice_ce} <= $urandom;
         pulse(2'h3);
         for (int c = 0; c < 4; c++)
            if (slice_ce[c / 2] && c < 2)
               lut[c][lut_addr[4*c+:4]] = bypass_in[c];
            else if (slice_ce[c / 2])
               lut[c] = {lut[c][14:0], bypass_in[c]};
      end
      slice_we <= 2'h0;
      for (int c = 0; c < 4; c++)
      begin
         bus(0, 6'(4 * c), 0);
         chk(rd, lut[c]);
      end
      // Slice 0 as one 32x1 memory; slice 1 dual-port, then 16x2; addresses and enables at random.
      slice_we <= 2'h3;
      for (int m = 0; m < 2; m++)
      begin
         bus(1, 6'h14, m ? 32'h0203 : 32'h0403);
         repeat (12)
         begin
            {lut_addr, bypass_in, slice_ce, ram_addr_hi} <= $urandom;
            pulse(2'h3);
            if (slice_ce[0])
               lut[ram_addr_hi[0]][lut_addr[3:0]] = bypass_in[0];
            for (int c = 2; c < 4; c++)
               if (slice_ce[1])
                  lut[c][lut_addr[11:8]] = m ? bypass_in[c] : bypass_in[2];
            chk(cell_out[0], lut[ram_addr_hi[0]][lut_addr[3:0]]);
            chk(cell_out[1], lut[1][lut_addr[3:0]]);
            chk(cell_out[2], lut[2][lut_addr[11:8]]);
            chk(cell_out[3], lut[3][m ? lut_addr[11:8] : lut_addr[15:12]]);
         end
      end
      // Back to logic mode with every cell's carry generate taken from the dedicated AND.
      slice_we <= 2'h0;
      bus(1, 6'h14, 0);
      bus(1, 6'h10, 32'h84210);
      andg = 4'hf;
      repeat (4) fabric_check();
      // A second reset in mid-run clears the tables again.
      reset_n <= 0;
      cyc(2);
      reset_n <= 1;
      bus(0, 6'h00, 0);
      chk(rd, 0);
      stop_test();
   end
endmodule // test_logic_tile
